// ===== hw/lps_pkg.sv
/*
 Constants for the L1 substates and containment register block: offsets,
 field positions, reset values and the containment trigger encodings.
 Assumes a 32-bit configuration data path with dword-aligned offsets.
*/
`default_nettype none
package lps_pkg;
   // Register offsets (byte addresses in configuration space)
   localparam logic [11:0] OFF_L1_HDR      = 12'h240;
   localparam logic [11:0] OFF_L1_CAP      = 12'h244;
   localparam logic [11:0] OFF_L1_CTRL1    = 12'h248;
   localparam logic [11:0] OFF_L1_CTRL2    = 12'h24c;
   localparam logic [11:0] OFF_CONT_HDR    = 12'h250;
   localparam logic [11:0] OFF_CONT_CAPCTL = 12'h254;
   localparam logic [11:0] OFF_CONT_STATUS = 12'h258;

   // Header fields
   localparam logic [15:0] ECAP_ID_L1SS    = 16'h001e;
   localparam logic [15:0] ECAP_ID_CONTAIN = 16'h001d;
   localparam logic [3:0]  CAP_VERSION     = 4'h1;
   localparam logic [11:0] NEXT_UPSTREAM   = 12'h260;
   localparam logic [11:0] NEXT_DOWNSTREAM = 12'h250;
   localparam logic [11:0] NEXT_NONE       = 12'h000;

   // L1 substates capability and control bits
   localparam int          CAP_PCIPM_BIT   = 1;
   localparam int          CAP_ASPM_BIT    = 3;
   localparam int          CAP_L1SS_BIT    = 4;
   localparam logic        CAP_PCIPM_RST   = 1'b1;
   localparam logic        CAP_ASPM_RST    = 1'b0;
   localparam logic        CAP_L1SS_RST    = 1'b1;
   localparam int          CTL_PCIPM_BIT   = 1;
   localparam int          CTL_ASPM_BIT    = 3;

   // Containment capability and control fields
   localparam logic [4:0]  CONT_MSI_NUM    = 5'h01;
   localparam int          CC_TRIG_LSB     = 16;
   localparam int          CC_CPL_BIT      = 18;
   localparam int          CC_INT_BIT      = 19;
   localparam int          CC_ERRCOR_BIT   = 20;

   // Containment status fields
   localparam int          ST_TRIG_BIT     = 0;
   localparam int          ST_REASON_LSB   = 1;
   localparam int          ST_INT_BIT      = 3;

   typedef enum logic [1:0] {
      TRIG_OFF      = 2'b00,
      TRIG_FATAL    = 2'b01,
      TRIG_NONFATAL = 2'b10,
      TRIG_RSVD     = 2'b11
   } lps_trig_t;

   typedef enum logic [1:0] {
      WHY_UNCOR    = 2'b00,
      WHY_NONFATAL = 2'b01,
      WHY_FATAL    = 2'b10
   } lps_reason_t;

   // Byte-enable merge of a configuration write into a stored word
   function automatic logic [31:0] lpsMerge(input logic [31:0] old,
                                            input logic [31:0] wr,
                                            input logic [3:0]  be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = wr[i*8 +: 8];
         end
      end
      return res;
   endfunction
endpackage
`default_nettype wire

// ===== hw/lps_trigger_eval.sv
/*
 Containment trigger decision: which error events fire under the
 programmed trigger mode, and the recorded cause.
 Assumes event inputs are single-cycle pulses in the core clock domain.
*/
`default_nettype none
module lps_trigger_eval (
   // Mode
   input  wire lps_pkg::lps_trig_t   trigMode,
   // Error events
   input  wire logic                 errUncor,
   input  wire logic                 msgNonfatal,
   input  wire logic                 msgFatal,
   // Decision
   output logic                      fire,
   output lps_pkg::lps_reason_t      reason
);
   import lps_pkg::*;

   // Reserved mode behaves as disabled so a stray write cannot arm it
   always_comb begin
      unique case (trigMode)
         TRIG_OFF:      fire = 1'b0;
         TRIG_FATAL:    fire = errUncor | msgFatal;
         TRIG_NONFATAL: fire = errUncor | msgFatal | msgNonfatal;
         TRIG_RSVD:     fire = 1'b0;
      endcase
   end

   // Own detected error takes priority in the recorded cause
   always_comb begin
      if (errUncor) begin
         reason = WHY_UNCOR;
      end else if (msgFatal) begin
         reason = WHY_FATAL;
      end else begin
         reason = WHY_NONFATAL;
      end
   end
endmodule
`default_nettype wire

// ===== hw/lps_contain_status.sv
/*
 Sticky containment status flags with write-one-to-clear.
 Assumes the caller only raises setTrig while the trigger flag is clear.
*/
`default_nettype none
module lps_contain_status (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 reset,
   // Hardware set
   input  wire logic                 setTrig,
   input  wire lps_pkg::lps_reason_t setReason,
   input  wire logic                 setInt,
   // Software clear (ones clear)
   input  wire logic [3:0]           clrMask,
   // Flags
   output logic [3:0]                status
);
   import lps_pkg::*;

   logic [3:0] status_q;
   logic [3:0] status_d;
   logic [3:0] setMask;

   // Set wins over a clear landing in the same cycle
   always_comb begin
      setMask = '0;
      setMask[ST_TRIG_BIT] = setTrig;
      setMask[ST_REASON_LSB +: 2] = setTrig ? setReason : 2'b00;
      setMask[ST_INT_BIT] = setInt;
      status_d = (status_q & ~clrMask) | setMask;
      if (setTrig) begin
         status_d[ST_REASON_LSB +: 2] = setReason;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         status_q <= 4'h0;
      end else begin
         status_q <= status_d;
      end
   end

   assign status = status_q;

   property p_set_wins;
      @(posedge clk) disable iff (reset)
      setTrig |=> status_q[ST_TRIG_BIT] && status_q[ST_REASON_LSB +: 2] == $past(setReason);
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("trigger flag or cause not recorded");

   property p_int_flag;
      @(posedge clk) disable iff (reset)
      setInt |=> status_q[ST_INT_BIT];
   endproperty
   a_int_flag: assert property (p_int_flag) else $error("interrupt status not set");
endmodule
`default_nettype wire

// ===== hw/lps_regs.sv
/*
 Per-port L1 substates and downstream containment register block.
 Configuration reads and writes arrive as single-cycle strobes; read data
 returns one cycle later. Non-volatile loaders may override the L1 support
 defaults. Port role is strapped and sampled while reset is held.
*/
`default_nettype none
// Behaviour
// - L1 header returns ID 001Eh and version 1h, read-only.
// - L1 header next pointer: 260h upstream, 250h downstream.
// - Capability bit 1 resets to 1; loader may replace it.
// - Capability bit 3 resets to 0; loaders may change it.
// - Capability bit 4 resets to 1; loader may alter it.
// - Control 1 bit 1 is read-write L1.1 PM enable, reset 0.
// - Control 1 bit 3 is read-write ASPM L1.1 enable, reset 0.
// - Control 2 reads all zeros and ignores writes.
// - Downstream containment header returns ID 001Dh, version 1h.
// - Containment header next pointer reads zero.
// - Containment capability bits 4:0 read 1 as message number.
// - Trigger field resets 00b: off; 01b uncorrectable or fatal.
// - Trigger 10b adds nonfatal messages; 11b reserved.
// - Bit 18 picks completion status: 0 abort, 1 unsupported.
// - Bit 19 enables the containment interrupt.
// - Bit 20 enables a correctable-error message on trigger.
// - Trigger sets sticky write-one-to-clear status bit 0.
// - Status bits 2:1 record the cause, write-one-to-clear.
// - Status bit 3 set on trigger with interrupt enabled.
module lps_regs (
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          reset,
   // Port role strap
   input  wire logic          portIsDownstream,
   // Configuration access
   input  wire logic          cfgWrite,
   input  wire logic          cfgRead,
   input  wire logic [11:0]   cfgAddr,
   input  wire logic [31:0]   cfgWrData,
   input  wire logic [3:0]    cfgByteEn,
   output logic [31:0]        cfgRdData,
   output logic               cfgRdValid,
   // Default override loader
   input  wire logic          capLoadValid,
   input  wire logic [2:0]    capLoadMask,
   input  wire logic [2:0]    capLoadData,
   // Error events
   input  wire logic          errUncorDetected,
   input  wire logic          msgErrNonfatal,
   input  wire logic          msgErrFatal,
   // Port controls and events
   output logic               pciPmL11Enable,
   output logic               aspmL11Enable,
   output logic               containActive,
   output logic               cplStatusUr,
   output logic               containIntReq,
   output logic               errCorReq
);
   import lps_pkg::*;

   logic              portDown_q;
   logic [2:0]        capBits_q;   // {l1ss, aspm, pcipm}
   logic              ctlPciPm_q;
   logic              ctlAspm_q;
   lps_trig_t         trigMode_q;
   logic              cplUr_q;
   logic              intEn_q;
   logic              errCorEn_q;
   logic [31:0]       rdData_q;
   logic              rdValid_q;
   logic              intReq_q;
   logic              errCor_q;
   logic              fire;
   lps_reason_t       fireReason;
   logic              accept;
   logic [3:0]        status;
   logic [3:0]        clrMask;
   logic [31:0]       ctl1Merged;
   logic [31:0]       contMerged;
   logic [31:0]       rdWord;
   logic [11:0]       wordAddr;
   logic              hitCtl1;
   logic              hitCont;
   logic              hitStatus;

   assign wordAddr  = {cfgAddr[11:2], 2'b00};
   assign hitCtl1   = cfgWrite && wordAddr == OFF_L1_CTRL1;
   assign hitCont   = cfgWrite && portDown_q && wordAddr == OFF_CONT_CAPCTL;
   assign hitStatus = cfgWrite && portDown_q && wordAddr == OFF_CONT_STATUS;

   // Role is caught while reset is held, so a later strap glitch is harmless
   always_ff @(posedge clk) begin
      if (reset) begin
         portDown_q <= portIsDownstream;
      end
   end

   // L1 support defaults; loaders override only the masked bits
   always_ff @(posedge clk) begin
      if (reset) begin
         capBits_q <= {CAP_L1SS_RST, CAP_ASPM_RST, CAP_PCIPM_RST};
      end else if (capLoadValid) begin
         capBits_q <= (capBits_q & ~capLoadMask) | (capLoadData & capLoadMask);
      end
   end

   // L1 substates control 1; other bits are not stored
   assign ctl1Merged = lpsMerge({28'h0, ctlAspm_q, 1'b0, ctlPciPm_q, 1'b0}, cfgWrData, cfgByteEn);

   always_ff @(posedge clk) begin
      if (reset) begin
         ctlPciPm_q <= 1'b0;
         ctlAspm_q  <= 1'b0;
      end else if (hitCtl1) begin
         ctlPciPm_q <= ctl1Merged[CTL_PCIPM_BIT];
         ctlAspm_q  <= ctl1Merged[CTL_ASPM_BIT];
      end
   end

   // Containment control; upstream ports hold it at reset values
   assign contMerged = lpsMerge({11'h0, errCorEn_q, intEn_q, cplUr_q, trigMode_q, 16'h0},
                                cfgWrData, cfgByteEn);

   always_ff @(posedge clk) begin
      if (reset) begin
         trigMode_q <= TRIG_OFF;
         cplUr_q    <= 1'b0;
         intEn_q    <= 1'b0;
         errCorEn_q <= 1'b0;
      end else if (hitCont) begin
         trigMode_q <= lps_trig_t'(contMerged[CC_TRIG_LSB +: 2]);
         cplUr_q    <= contMerged[CC_CPL_BIT];
         intEn_q    <= contMerged[CC_INT_BIT];
         errCorEn_q <= contMerged[CC_ERRCOR_BIT];
      end
   end

   lps_trigger_eval u_trig (
      .trigMode    (trigMode_q),
      .errUncor    (errUncorDetected),
      .msgNonfatal (msgErrNonfatal),
      .msgFatal    (msgErrFatal),
      .fire        (fire),
      .reason      (fireReason)
   );

   // A new trigger is taken only while not already contained
   assign accept = fire && portDown_q && !status[ST_TRIG_BIT];

   // Software clears status with ones in the low byte only
   always_comb begin
      clrMask = 4'h0;
      if (hitStatus && cfgByteEn[0]) begin
         clrMask = cfgWrData[3:0];
      end
   end

   lps_contain_status u_status (
      .clk       (clk),
      .reset     (reset),
      .setTrig   (accept),
      .setReason (fireReason),
      .setInt    (accept && intEn_q),
      .clrMask   (clrMask),
      .status    (status)
   );

   // Event pulses one cycle after the trigger is taken
   always_ff @(posedge clk) begin
      if (reset) begin
         intReq_q <= 1'b0;
         errCor_q <= 1'b0;
      end else begin
         intReq_q <= accept && intEn_q;
         errCor_q <= accept && errCorEn_q;
      end
   end

   // Read decode; unlisted offsets and reserved bits return zero
   always_comb begin
      rdWord = 32'h0;
      unique case (wordAddr)
         OFF_L1_HDR:
            rdWord = {portDown_q ? NEXT_DOWNSTREAM : NEXT_UPSTREAM, CAP_VERSION, ECAP_ID_L1SS};
         OFF_L1_CAP: begin
            rdWord[CAP_PCIPM_BIT] = capBits_q[0];
            rdWord[CAP_ASPM_BIT]  = capBits_q[1];
            rdWord[CAP_L1SS_BIT]  = capBits_q[2];
         end
         OFF_L1_CTRL1: begin
            rdWord[CTL_PCIPM_BIT] = ctlPciPm_q;
            rdWord[CTL_ASPM_BIT]  = ctlAspm_q;
         end
         OFF_L1_CTRL2:
            rdWord = 32'h0;
         OFF_CONT_HDR:
            if (portDown_q) begin
               rdWord = {NEXT_NONE, CAP_VERSION, ECAP_ID_CONTAIN};
            end
         OFF_CONT_CAPCTL:
            if (portDown_q) begin
               rdWord = {11'h0, errCorEn_q, intEn_q, cplUr_q, trigMode_q, 11'h0, CONT_MSI_NUM};
            end
         OFF_CONT_STATUS:
            if (portDown_q) begin
               rdWord = {28'h0, status};
            end
         default:
            rdWord = 32'h0;
      endcase
   end

   // Read data is registered; it holds until the next read
   always_ff @(posedge clk) begin
      if (reset) begin
         rdData_q  <= 32'h0;
         rdValid_q <= 1'b0;
      end else begin
         rdValid_q <= cfgRead;
         if (cfgRead) begin
            rdData_q <= rdWord;
         end
      end
   end

   assign cfgRdData      = rdData_q;
   assign cfgRdValid     = rdValid_q;
   assign pciPmL11Enable = ctlPciPm_q;
   assign aspmL11Enable  = ctlAspm_q;
   assign containActive  = status[ST_TRIG_BIT];
   assign cplStatusUr    = cplUr_q;
   assign containIntReq  = intReq_q;
   assign errCorReq      = errCor_q;

   property p_l1_header;
      @(posedge clk) disable iff (reset)
      cfgRead && wordAddr == OFF_L1_HDR |=> cfgRdValid && cfgRdData[19:0] == 20'h1001e;
   endproperty
   a_l1_header: assert property (p_l1_header) else $error("L1 header ID or version wrong");

   property p_next_ptr;
      @(posedge clk) disable iff (reset)
      cfgRead && wordAddr == OFF_L1_HDR |=>
         cfgRdData[31:20] == (portDown_q ? 12'h250 : 12'h260);
   endproperty
   a_next_ptr: assert property (p_next_ptr) else $error("L1 next pointer wrong for port role");

   property p_cap_reset;
      @(posedge clk)
      $fell(reset) |-> capBits_q == 3'b101;
   endproperty
   a_cap_reset: assert property (p_cap_reset) else $error("L1 support defaults wrong after reset");

   property p_ctl1_write;
      @(posedge clk) disable iff (reset)
      hitCtl1 && cfgByteEn[0] |=> ctlAspm_q == $past(cfgWrData[3]) && ctlPciPm_q == $past(cfgWrData[1]);
   endproperty
   a_ctl1_write: assert property (p_ctl1_write) else $error("control 1 enable not written");

   property p_ctl2_zero;
      @(posedge clk) disable iff (reset)
      cfgRead && wordAddr == OFF_L1_CTRL2 |=> cfgRdData == 32'h0;
   endproperty
   a_ctl2_zero: assert property (p_ctl2_zero) else $error("control 2 not zero");

   property p_cont_hdr;
      @(posedge clk) disable iff (reset)
      cfgRead && portDown_q && wordAddr == OFF_CONT_HDR |=> cfgRdData == 32'h0001001d;
   endproperty
   a_cont_hdr: assert property (p_cont_hdr) else $error("containment header wrong");

   property p_msi_num;
      @(posedge clk) disable iff (reset)
      cfgRead && portDown_q && wordAddr == OFF_CONT_CAPCTL |=> cfgRdData[15:0] == 16'h0001;
   endproperty
   a_msi_num: assert property (p_msi_num) else $error("message number not 1");

   property p_trig_off;
      @(posedge clk) disable iff (reset)
      trigMode_q == TRIG_OFF || trigMode_q == TRIG_RSVD |-> !accept;
   endproperty
   a_trig_off: assert property (p_trig_off) else $error("trigger while disabled");

   property p_nonfatal;
      @(posedge clk) disable iff (reset)
      portDown_q && !status[0] && msgErrNonfatal && trigMode_q == TRIG_NONFATAL ##1 !cfgWrite
         |-> status[0] && status[2:1] != 2'b00 || $past(errUncorDetected);
   endproperty
   a_nonfatal: assert property (p_nonfatal) else $error("nonfatal message did not contain");

   property p_events;
      @(posedge clk) disable iff (reset)
      accept |=> containIntReq == $past(intEn_q) && errCorReq == $past(errCorEn_q) ##1
         !containIntReq && !errCorReq;
   endproperty
   a_events: assert property (p_events) else $error("interrupt or message pulse wrong");

   property p_reserved;
      @(posedge clk) disable iff (reset)
      cfgRead && wordAddr == OFF_L1_CTRL1 |=> cfgRdData[31:4] == 28'h0 && !cfgRdData[0] && !cfgRdData[2];
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits not zero");
endmodule
`default_nettype wire

// ===== bench/lps_cfg_host.sv
/*
 Configuration software model: single-cycle read and write strobes.
 Assumes the bench clock; drives on the falling edge, one access at a time.
*/
`default_nettype none
module lps_cfg_host (
   // Clock
   input  wire logic        clk,
   // Configuration access
   output var  logic        cfgWrite,
   output var  logic        cfgRead,
   output var  logic [11:0] cfgAddr,
   output var  logic [31:0] cfgWrData,
   output var  logic [3:0]  cfgByteEn,
   input  wire logic [31:0] cfgRdData,
   input  wire logic        cfgRdValid
);
   timeunit 1ns;
   timeprecision 100ps;

   // Idle bus at time zero
   initial begin
      cfgWrite  = 1'b0;
      cfgRead   = 1'b0;
      cfgAddr   = 12'h000;
      cfgWrData = 32'h0;
      cfgByteEn = 4'h0;
   end

   // One write; released address and data show the inverse so stale values never match
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
      @(negedge clk);
      cfgAddr   = a;
      cfgWrData = d;
      cfgByteEn = be;
      cfgWrite  = 1'b1;
      @(negedge clk);
      cfgWrite  = 1'b0;
      cfgAddr   = ~a;
      cfgWrData = ~d;
      cfgByteEn = 4'h0;
   endtask

   // One read; the answer is taken one cycle after the strobe
   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic ok);
      @(negedge clk);
      cfgAddr = a;
      cfgRead = 1'b1;
      @(negedge clk);
      cfgRead = 1'b0;
      cfgAddr = ~a;
      ok      = cfgRdValid;
      d       = cfgRdData;
   endtask
endmodule
`default_nettype wire

// ===== bench/l1pm_substates_and_containment_regs_test.sv
/*
 Self-checking bench for the L1 substates and containment register block.
 Assumes the configuration host model in its own file; no other masters.
*/
`default_nettype none
module l1pm_substates_and_containment_regs_test;
   timeunit 1ns;
   timeprecision 100ps;

   // Clock, reset and pins
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        portIsDownstream = 1'b1;
   logic        cfgWrite, cfgRead, cfgRdValid;
   logic [11:0] cfgAddr;
   logic [31:0] cfgWrData, cfgRdData;
   logic [3:0]  cfgByteEn;
   logic        capLoadValid = 1'b0;
   logic [2:0]  capLoadMask = 3'h0;
   logic [2:0]  capLoadData = 3'h0;
   logic [2:0]  ev = 3'h0;
   logic        pciPmL11Enable, aspmL11Enable, containActive, cplStatusUr, containIntReq, errCorReq;
   int          n_errors = 0;
   int          n_compared = 0;

   // Read rows after reset: address, expected word
   logic [11:0] rdAddr[8] = '{12'h240, 12'h244, 12'h248, 12'h24c, 12'h250, 12'h254, 12'h258, 12'h300};
   logic [31:0] rdExp[8]  = '{32'h2501001e, 32'h12, 32'h0, 32'h0, 32'h0001001d, 32'h1, 32'h0, 32'h0};
   // Trigger rows: control bits 20:16, events {uncor, nonfatal, fatal}, status
   logic [11:0] trigRow[7] = '{12'h070, 12'h1f0, 12'h0a0, 12'h0c1, 12'h49d, 12'h923, 12'h371};

   initial begin
      forever #2.5 clk = ~clk;
   end

   lps_cfg_host i_host (.clk(clk), .cfgWrite(cfgWrite), .cfgRead(cfgRead), .cfgAddr(cfgAddr),
      .cfgWrData(cfgWrData), .cfgByteEn(cfgByteEn), .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid));

   lps_regs i_dut (.clk(clk), .reset(reset), .portIsDownstream(portIsDownstream), .cfgWrite(cfgWrite),
      .cfgRead(cfgRead), .cfgAddr(cfgAddr), .cfgWrData(cfgWrData), .cfgByteEn(cfgByteEn),
      .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid), .capLoadValid(capLoadValid),
      .capLoadMask(capLoadMask), .capLoadData(capLoadData), .errUncorDetected(ev[2]),
      .msgErrNonfatal(ev[1]), .msgErrFatal(ev[0]), .pciPmL11Enable(pciPmL11Enable),
      .aspmL11Enable(aspmL11Enable), .containActive(containActive), .cplStatusUr(cplStatusUr),
      .containIntReq(containIntReq), .errCorReq(errCorReq));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic        ok;
      i_host.rd(a, d, ok);
      chk("cfgRdValid", 32'h1, {31'h0, ok});
      chk($sformatf("read %h", a), exp, d);
   endtask

   // Strap sampled while reset is held for two cycles
   task automatic doReset(input logic down);
      @(negedge clk);
      reset = 1'b1;
      portIsDownstream = down;
      repeat (2) @(negedge clk);
      reset = 1'b0;
   endtask

   // One-cycle event pulse; level and pulse outputs looked at in the cycle after
   task automatic pulse(input logic [2:0] e, input logic act, input logic irq, input logic cor);
      @(negedge clk);
      ev = e;
      @(negedge clk);
      ev = 3'h0;
      chk("containActive", {31'h0, act}, {31'h0, containActive});
      chk("containIntReq", {31'h0, irq}, {31'h0, containIntReq});
      chk("errCorReq", {31'h0, cor}, {31'h0, errCorReq});
      @(negedge clk);
      chk("containIntReq end", 32'h0, {31'h0, containIntReq});
      chk("errCorReq end", 32'h0, {31'h0, errCorReq});
   endtask

   task automatic load(input logic [2:0] m, input logic [2:0] d);
      @(negedge clk);
      capLoadValid = 1'b1;
      capLoadMask  = m;
      capLoadData  = d;
      @(negedge clk);
      capLoadValid = 1'b0;
   endtask

   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Whole run is about 160 cycles; this bound is far beyond it
   initial begin
      #20000;
      n_errors++;
      $display("[ERR] watchdog expected finish seen timeout");
      close_out();
   end

   initial begin
      logic [4:0] ctl;
      logic [3:0] st;
      repeat (2) @(negedge clk);
      reset = 1'b0;
      // Reset values of every word, plus an unmapped place
      for (int i = 0; i < 8; i++) begin
         rdChk(rdAddr[i], rdExp[i]);
      end
      $display("test reset values done");
      // Every trigger mode; all three event kinds one at a time under the fatal mode
      for (int i = 0; i < 7; i++) begin
         ctl = trigRow[i][11:7];
         st  = trigRow[i][3:0];
         i_host.wr(12'h254, {11'h0, ctl, 16'h0}, 4'hc);
         rdChk(12'h254, {11'h0, ctl, 16'h1});
         chk("cplStatusUr", {31'h0, ctl[2]}, {31'h0, cplStatusUr});
         pulse(trigRow[i][6:4], st[0], st[3], ctl[4] & st[0]);
         rdChk(12'h258, {28'h0, st});
         i_host.wr(12'h258, 32'h0000000f, 4'h1);
         rdChk(12'h258, 32'h0);
      end
      $display("test trigger modes done");
      // Read-write enables, reserved and read-only words ignore writes
      i_host.wr(12'h248, 32'hffffffff, 4'hf);
      rdChk(12'h248, 32'h0000000a);
      chk("pciPmL11Enable", 32'h1, {31'h0, pciPmL11Enable});
      chk("aspmL11Enable", 32'h1, {31'h0, aspmL11Enable});
      i_host.wr(12'h24c, 32'hffffffff, 4'hf);
      rdChk(12'h24c, 32'h0);
      i_host.wr(12'h240, 32'h0, 4'hf);
      rdChk(12'h240, 32'h2501001e);
      i_host.wr(12'h244, 32'h0, 4'hf);
      rdChk(12'h244, 32'h00000012);
      $display("test writes done");
      // Loader overrides the support defaults
      load(3'h7, 3'h2);
      rdChk(12'h244, 32'h00000008);
      load(3'h1, 3'h1);
      rdChk(12'h244, 32'h0000000a);
      $display("test loader done");
      // A second event while contained keeps the first cause
      i_host.wr(12'h254, 32'h00020000, 4'hc);
      pulse(3'h2, 1'b1, 1'b0, 1'b0);
      pulse(3'h1, 1'b1, 1'b0, 1'b0);
      rdChk(12'h258, 32'h3);
      $display("test no overwrite done");
      // Mid-run reset as an upstream port
      doReset(1'b0);
      rdChk(12'h240, 32'h2601001e);
      rdChk(12'h248, 32'h0);
      rdChk(12'h244, 32'h00000012);
      rdChk(12'h250, 32'h0);
      i_host.wr(12'h254, 32'h00010000, 4'hc);
      rdChk(12'h254, 32'h0);
      pulse(3'h1, 1'b0, 1'b0, 1'b0);
      $display("test upstream done");
      close_out();
   end
endmodule
`default_nettype wire
